/* ckg_sync.sv */
module ckg_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input logic clk,
	input logic rst,
	// levels from outside this clock domain
	input logic [WIDTH-1:0] asyncIn,
	// levels after two flip-flops
	output logic [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} ckg_sync_regs_type;

	ckg_sync_regs_type q;
	ckg_sync_regs_type d;

	if (WIDTH < 1) begin : g_check
		$error("ckg_sync needs a width of at least one");
	end

	// stage1 feeds stage2 only
	always_comb begin
		d = q;
		d.stage1 = asyncIn;
		d.stage2 = q.stage1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign syncOut = q.stage2;
endmodule

/* ckg_clock_switch.sv */
module ckg_clock_switch #(
	parameter int EDGES = 3
) (
	// clock and reset
	input logic clk,
	input logic rst,
	// synchronised source levels
	input logic crystalLevel,
	input logic loopLevel,
	// requested source, high for the loop clock
	input logic selectLoop,
	// results
	output logic baseClock,
	output logic activeLoop,
	output logic switching
);
	localparam int CW = $clog2(EDGES + 1);

	typedef enum logic [1:0] {
		RUN,
		DRAIN,
		FILL
	} ckg_switch_state_type;

	typedef struct packed {
		ckg_switch_state_type state;
		logic [CW-1:0] edgeCount;
		logic crystalPrev;
		logic loopPrev;
		logic activeLoop;
		logic baseClock;
	} ckg_switch_regs_type;

	ckg_switch_regs_type q;
	ckg_switch_regs_type d;
	logic crystalRise;
	logic loopRise;
	logic oldRise;
	logic newRise;

	if (EDGES < 1) begin : g_check
		$error("ckg_clock_switch needs at least one edge per side");
	end

	assign crystalRise = crystalLevel & ~q.crystalPrev;
	assign loopRise = loopLevel & ~q.loopPrev;
	assign oldRise = q.activeLoop ? loopRise : crystalRise;
	assign newRise = q.activeLoop ? crystalRise : loopRise;

	always_comb begin
		d = q;
		d.crystalPrev = crystalLevel;
		d.loopPrev = loopLevel;
		case (q.state)
			RUN: begin
				if (selectLoop != q.activeLoop) begin
					d.state = DRAIN;
					d.edgeCount = '0;
				end else if (oldRise) begin
					d.baseClock = ~q.baseClock;
				end
			end
			DRAIN: begin
				// old source gated off; output held where it stood
				if (oldRise) begin
					if (q.edgeCount == CW'(EDGES - 1)) begin
						d.state = FILL;
						d.edgeCount = '0;
					end else begin
						d.edgeCount = q.edgeCount + CW'(1);
					end
				end
			end
			FILL: begin
				if (newRise) begin
					if (q.edgeCount == CW'(EDGES - 1)) begin
						d.state = RUN;
						d.edgeCount = '0;
						d.activeLoop = ~q.activeLoop;
					end else begin
						d.edgeCount = q.edgeCount + CW'(1);
					end
				end
			end
			default: begin
				d.state = RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{state: RUN, edgeCount: '0, crystalPrev: 1'b0, loopPrev: 1'b0,
				activeLoop: 1'b0, baseClock: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign baseClock = q.baseClock;
	assign activeLoop = q.activeLoop;
	assign switching = (q.state != RUN);
endmodule

/* ckg_base_clock_ctrl.sv */
// Summary of operation
// - bus clock is one quarter of the selected source clock.
// - source change waits three old and three new edges, output held.
// - switch output is divided by two for an even duty cycle.
// - base clock output has 50 percent duty, twice the bus rate.
// - loop source cannot be selected while loop power is off.
// - loop power cannot be cleared while loop source is selected.
// - power and source change need separate writes; only legal order honoured.
// - usb reference follows selection: crystal or undivided vco clock.
// - zero reference divider or multiplier acts as one.
// - zero range disables loop and blocks its selection.
// - vco rate is reference times two to prescale times multiplier over divider.
// - oscillator enable input enables crystal oscillator and loop.
// - lock-change interrupt output comes from the lock detector.
// - buffered copy of oscillator input is driven out.
// - select one: loop clock halved and vco to usb; zero: crystal for both.
// - reset clears source select, crystal is the source.
// - flag sets on each lock toggle in automatic mode, clears on control register read.
package ckg_pkg;
	// register offsets
	localparam logic [7:0] ADDR_CONTROL = 8'h3a;
	localparam logic [7:0] ADDR_BANDWIDTH = 8'h3b;
	localparam logic [7:0] ADDR_MULT_HIGH = 8'h3c;
	localparam logic [7:0] ADDR_MULT_LOW = 8'h3d;
	localparam logic [7:0] ADDR_REF_DIV = 8'h3f;
	localparam logic [7:0] ADDR_RANGE = 8'h40;
	// control register fields
	localparam int CTL_IRQ_EN = 7;
	localparam int CTL_FLAG = 6;
	localparam int CTL_POWER = 5;
	localparam int CTL_SELECT = 4;
	localparam int CTL_PRE_HI = 3;
	localparam int CTL_PRE_LO = 2;
	// bandwidth register fields
	localparam int BW_AUTO = 7;
	localparam int BW_LOCK = 6;
	localparam int BW_ACQ = 5;
	// field widths
	localparam int DATA_WIDTH = 8;
	localparam int MULT_WIDTH = 12;
	localparam int REF_WIDTH = 4;
	localparam int RANGE_WIDTH = 8;
	localparam int PRE_WIDTH = 2;
	// reset values
	localparam logic RST_IRQ_EN = 1'h0;
	localparam logic RST_POWER = 1'h1;
	localparam logic RST_SELECT = 1'h0;
	localparam logic RST_AUTO = 1'h0;
	localparam logic [1:0] RST_PRESCALE = 2'h0;
	localparam logic [11:0] RST_MULT = 12'h002;
	localparam logic [3:0] RST_REF = 4'h1;
	localparam logic [7:0] RST_RANGE = 8'h01;
	// timing
	localparam int SWITCH_EDGES = 3;
	// index of each pin in the synchroniser vector
	localparam int PIN_CRYSTAL = 0;
	localparam int PIN_LOOP = 1;
	localparam int PIN_VCO = 2;
	localparam int PIN_OSC = 3;
	localparam int PIN_LOCK = 4;
	localparam int PIN_ACQ = 5;
	localparam int PIN_COUNT = 6;
endpackage

module ckg_base_clock_ctrl #(
	parameter int ADDR_WIDTH = 8,
	parameter int SWITCH_EDGES = ckg_pkg::SWITCH_EDGES
) (
	// clock and reset
	input logic clk,
	input logic rst,
	// register port
	input logic [ADDR_WIDTH-1:0] regAddr,
	input logic [ckg_pkg::DATA_WIDTH-1:0] regWriteData,
	input logic regWrite,
	input logic regRead,
	output logic [ckg_pkg::DATA_WIDTH-1:0] regReadData,
	// clock pins
	input logic crystalClock,
	input logic loopClock,
	input logic vcoClock,
	input logic oscInput,
	// lock detector
	input logic lockDetect,
	input logic acqDetect,
	// system integration logic
	input logic oscEnableIn,
	output logic baseClockOut,
	// usb
	output logic usbRefClock,
	// external clock and interrupt
	output logic bufferedOscOut,
	output logic lockChangeIrq,
	// analog loop controls
	output logic crystalOscEnable,
	output logic loopEnable,
	output logic autoBandwidth,
	output logic [ckg_pkg::PRE_WIDTH-1:0] prescaleOut,
	output logic [ckg_pkg::MULT_WIDTH-1:0] multiplierOut,
	output logic [ckg_pkg::REF_WIDTH-1:0] refDividerOut,
	output logic [ckg_pkg::RANGE_WIDTH-1:0] rangeOut
);
	typedef struct packed {
		logic irqEnable;
		logic flag;
		logic powerOn;
		logic select;
		logic autoMode;
		logic [ckg_pkg::PRE_WIDTH-1:0] prescale;
		logic [ckg_pkg::MULT_WIDTH-1:0] multiplier;
		logic [ckg_pkg::REF_WIDTH-1:0] refDivider;
		logic [ckg_pkg::RANGE_WIDTH-1:0] range;
		logic lockPrev;
		logic [ckg_pkg::DATA_WIDTH-1:0] readData;
		logic irq;
		logic loopOn;
		logic oscOn;
		logic usbClock;
		logic oscBuffer;
		logic [ckg_pkg::MULT_WIDTH-1:0] multEff;
		logic [ckg_pkg::REF_WIDTH-1:0] refEff;
	} ckg_ctrl_regs_type;

	localparam ckg_ctrl_regs_type RESET_REGS = '{
		irqEnable: ckg_pkg::RST_IRQ_EN,
		flag: 1'b0,
		powerOn: ckg_pkg::RST_POWER,
		select: ckg_pkg::RST_SELECT,
		autoMode: ckg_pkg::RST_AUTO,
		prescale: ckg_pkg::RST_PRESCALE,
		multiplier: ckg_pkg::RST_MULT,
		refDivider: ckg_pkg::RST_REF,
		range: ckg_pkg::RST_RANGE,
		lockPrev: 1'b0,
		readData: '0,
		irq: 1'b0,
		loopOn: 1'b0,
		oscOn: 1'b0,
		usbClock: 1'b0,
		oscBuffer: 1'b0,
		multEff: ckg_pkg::RST_MULT,
		refEff: ckg_pkg::RST_REF
	};

	ckg_ctrl_regs_type q;
	ckg_ctrl_regs_type d;

	logic [ckg_pkg::PIN_COUNT-1:0] pinRaw;
	logic [ckg_pkg::PIN_COUNT-1:0] pinSync;
	logic crystalSync;
	logic loopSync;
	logic vcoSync;
	logic oscSync;
	logic lockSync;
	logic acqSync;
	logic switchBase;
	logic switchActiveLoop;
	logic lockToggle;
	logic rangeNonzero;
	logic [7:0] addr8;

	if (ADDR_WIDTH < 7 || ADDR_WIDTH > 8) begin : g_check_addr
		$error("ckg_base_clock_ctrl needs an address width of 7 or 8");
	end
	if (SWITCH_EDGES < 1) begin : g_check_edges
		$error("ckg_base_clock_ctrl needs at least one switch edge");
	end

	// a zero field would be meaningless to the analog dividers
	function automatic logic [ckg_pkg::MULT_WIDTH-1:0] zeroAsOne(
		input logic [ckg_pkg::MULT_WIDTH-1:0] value
	);
		if (value == '0) begin
			zeroAsOne = ckg_pkg::MULT_WIDTH'(1);
		end else begin
			zeroAsOne = value;
		end
	endfunction

	// every clock and lock detector pin, the source clocks too, passes two flops before use; oscEnableIn does not
	assign pinRaw[ckg_pkg::PIN_CRYSTAL] = crystalClock;
	assign pinRaw[ckg_pkg::PIN_LOOP] = loopClock;
	assign pinRaw[ckg_pkg::PIN_VCO] = vcoClock;
	assign pinRaw[ckg_pkg::PIN_OSC] = oscInput;
	assign pinRaw[ckg_pkg::PIN_LOCK] = lockDetect;
	assign pinRaw[ckg_pkg::PIN_ACQ] = acqDetect;

	ckg_sync #(
		.WIDTH(ckg_pkg::PIN_COUNT)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.asyncIn(pinRaw),
		.syncOut(pinSync)
	);

	assign crystalSync = pinSync[ckg_pkg::PIN_CRYSTAL];
	assign loopSync = pinSync[ckg_pkg::PIN_LOOP];
	assign vcoSync = pinSync[ckg_pkg::PIN_VCO];
	assign oscSync = pinSync[ckg_pkg::PIN_OSC];
	assign lockSync = pinSync[ckg_pkg::PIN_LOCK];
	assign acqSync = pinSync[ckg_pkg::PIN_ACQ];

	// sampling limits usable source rates to well under half of clk
	ckg_clock_switch #(
		.EDGES(SWITCH_EDGES)
	) u_switch (
		.clk(clk),
		.rst(rst),
		.crystalLevel(crystalSync),
		.loopLevel(loopSync),
		.selectLoop(q.select),
		.baseClock(switchBase),
		.activeLoop(switchActiveLoop),
		.switching()
	);

	assign addr8 = 8'(regAddr);
	// entry into and exit from lock both count as a change
	assign lockToggle = lockSync ^ q.lockPrev;
	assign rangeNonzero = (q.range != '0);

	always_comb begin
		d = q;
		d.readData = '0;
		d.lockPrev = lockSync;

		// register reads, data valid in the next cycle only
		if (regRead) begin
			if (addr8 == ckg_pkg::ADDR_CONTROL) begin
				d.readData[ckg_pkg::CTL_IRQ_EN] = q.irqEnable;
				d.readData[ckg_pkg::CTL_FLAG] = q.flag & q.autoMode;
				d.readData[ckg_pkg::CTL_POWER] = q.powerOn;
				d.readData[ckg_pkg::CTL_SELECT] = q.select;
				d.readData[ckg_pkg::CTL_PRE_HI] = q.prescale[1];
				d.readData[ckg_pkg::CTL_PRE_LO] = q.prescale[0];
				d.flag = 1'b0;
			end else if (addr8 == ckg_pkg::ADDR_BANDWIDTH) begin
				d.readData[ckg_pkg::BW_AUTO] = q.autoMode;
				d.readData[ckg_pkg::BW_LOCK] = lockSync & q.autoMode;
				d.readData[ckg_pkg::BW_ACQ] = acqSync;
			end else if (addr8 == ckg_pkg::ADDR_MULT_HIGH) begin
				d.readData = 8'(q.multiplier[ckg_pkg::MULT_WIDTH-1:8]);
			end else if (addr8 == ckg_pkg::ADDR_MULT_LOW) begin
				d.readData = q.multiplier[7:0];
			end else if (addr8 == ckg_pkg::ADDR_REF_DIV) begin
				d.readData = 8'(q.refDivider);
			end else if (addr8 == ckg_pkg::ADDR_RANGE) begin
				d.readData = q.range;
			end else begin
				// unmapped offsets read as zero
				d.readData = '0;
			end
		end

		// register writes
		if (regWrite) begin
			if (addr8 == ckg_pkg::ADDR_CONTROL) begin
				d.irqEnable = regWriteData[ckg_pkg::CTL_IRQ_EN];
				// old select keeps power on; old power gates new select
				d.powerOn = regWriteData[ckg_pkg::CTL_POWER] | q.select;
				d.select = regWriteData[ckg_pkg::CTL_SELECT] & q.powerOn
					& rangeNonzero;
				// dividers must not move under a running loop
				if (!q.powerOn) begin
					d.prescale = regWriteData[ckg_pkg::CTL_PRE_HI:ckg_pkg::CTL_PRE_LO];
				end
			end else if (addr8 == ckg_pkg::ADDR_BANDWIDTH) begin
				d.autoMode = regWriteData[ckg_pkg::BW_AUTO];
			end else if (addr8 == ckg_pkg::ADDR_MULT_HIGH) begin
				if (!q.powerOn) begin
					d.multiplier[ckg_pkg::MULT_WIDTH-1:8] = regWriteData[3:0];
				end
			end else if (addr8 == ckg_pkg::ADDR_MULT_LOW) begin
				if (!q.powerOn) begin
					d.multiplier[7:0] = regWriteData;
				end
			end else if (addr8 == ckg_pkg::ADDR_REF_DIV) begin
				if (!q.powerOn) begin
					d.refDivider = regWriteData[ckg_pkg::REF_WIDTH-1:0];
				end
			end else if (addr8 == ckg_pkg::ADDR_RANGE) begin
				if (!q.powerOn) begin
					d.range = regWriteData;
				end
			end
		end

		// interrupt enable only exists in automatic mode
		if (!d.autoMode) begin
			d.irqEnable = 1'b0;
		end

		// a lock toggle beats a clearing read in the same cycle
		if (lockToggle && q.autoMode) begin
			d.flag = 1'b1;
		end

		// zero range never lets the loop drive the base clock
		if (d.range == '0) begin
			d.select = 1'b0;
		end

		d.irq = d.flag & d.irqEnable;
		d.oscOn = oscEnableIn;
		// loop only runs with the oscillator that feeds it
		d.loopOn = d.powerOn & oscEnableIn & (d.range != '0);
		d.oscBuffer = oscSync;
		// usb follows the source actually in use, not the request
		d.usbClock = switchActiveLoop ? vcoSync : crystalSync;
		d.multEff = zeroAsOne(d.multiplier);
		d.refEff = ckg_pkg::REF_WIDTH'(zeroAsOne(
			ckg_pkg::MULT_WIDTH'(d.refDivider)));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RESET_REGS;
		end else begin
			q <= d;
		end
	end

	// outputs come straight from registers, base clock from the switch
	assign regReadData = q.readData;
	assign baseClockOut = switchBase;
	assign usbRefClock = q.usbClock;
	assign bufferedOscOut = q.oscBuffer;
	assign lockChangeIrq = q.irq;
	assign crystalOscEnable = q.oscOn;
	assign loopEnable = q.loopOn;
	assign autoBandwidth = q.autoMode;
	assign prescaleOut = q.prescale;
	assign multiplierOut = q.multEff;
	assign refDividerOut = q.refEff;
	assign rangeOut = q.range;
endmodule

/* ckg_ctrl_asserts.sv */
module ckg_ctrl_asserts (
	// clock and reset
	input logic clk,
	input logic rst,
	// watched ports
	input logic oscInput,
	input logic oscEnableIn,
	input logic crystalOscEnable,
	input logic loopEnable,
	input logic baseClockOut,
	input logic usbRefClock,
	input logic bufferedOscOut,
	input logic [ckg_pkg::MULT_WIDTH-1:0] multiplierOut,
	input logic [ckg_pkg::REF_WIDTH-1:0] refDividerOut,
	input logic [ckg_pkg::RANGE_WIDTH-1:0] rangeOut
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_osc_en_follow: assert property (
		!$past(rst) |-> crystalOscEnable == $past(oscEnableIn)
	) else $error("oscillator enable not passed on");
	a_loop_needs_osc: assert property (
		!$past(rst) && !$past(oscEnableIn) |-> !loopEnable
	) else $error("loop runs without oscillator enable");
	a_range_zero_off: assert property (
		$past(rangeOut) == 8'h00 |-> !loopEnable
	) else $error("loop runs with zero range");
	a_mult_nonzero: assert property (
		multiplierOut != 12'h000
	) else $error("multiplier shown as zero");
	a_div_nonzero: assert property (
		refDividerOut != 4'h0
	) else $error("divider shown as zero");
	// a synced edge can come at most every second cycle
	a_base_half_rate: assert property (
		$changed(baseClockOut) |=> $stable(baseClockOut)
	) else $error("base clock toggled twice in a row");
	a_buf_osc_delay: assert property (
		!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> bufferedOscOut == $past(oscInput, 3)
	) else $error("buffered oscillator copy wrong");
	a_reset_crystal: assert property (
		$fell(rst) |-> !baseClockOut && !usbRefClock
	) else $error("clock outputs not quiet after reset");
endmodule

/* ckg_sil_model.sv */
module ckg_sil_model (
	// clock and reset
	input logic clk,
	input logic rst,
	// control from bench and clock from device
	input logic enableReq,
	input logic baseClockOut,
	// oscillator enable and measured half periods
	output logic oscEnableIn,
	output int highLen,
	output int lowLen
);
	timeunit 1ns;
	timeprecision 1ns;
	int run;
	logic last;
	always @(posedge clk) begin
		oscEnableIn <= enableReq;
		last <= baseClockOut;
		if (rst) begin
			run <= 0;
		end else if (baseClockOut !== last) begin
			// only full halves are recorded, so a stalled clock keeps old lengths
			if (last === 1'h1) begin
				highLen <= run;
			end else begin
				lowLen <= run;
			end
			run <= 1;
		end else begin
			run <= run + 1;
		end
	end
endmodule

/* testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] CTL = ckg_pkg::ADDR_CONTROL;
	localparam logic [7:0] BW = ckg_pkg::ADDR_BANDWIDTH;
	logic clk, rst, regWrite, regRead, enableReq, oscEnableIn;
	logic [7:0] regAddr, regWriteData, regReadData, rangeOut;
	logic crystalClock, loopClock, vcoClock, oscInput, lockDetect, acqDetect;
	logic baseClockOut, usbRefClock, bufferedOscOut, lockChangeIrq;
	logic crystalOscEnable, loopEnable, autoBandwidth;
	logic [1:0] prescaleOut;
	logic [11:0] multiplierOut;
	logic [3:0] refDividerOut;
	int highLen, lowLen, failCount, nChecks;

	ckg_base_clock_ctrl u_dut (
		.clk, .rst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
		.crystalClock, .loopClock, .vcoClock, .oscInput, .lockDetect, .acqDetect,
		.oscEnableIn, .baseClockOut, .usbRefClock, .bufferedOscOut, .lockChangeIrq,
		.crystalOscEnable, .loopEnable, .autoBandwidth, .prescaleOut, .multiplierOut,
		.refDividerOut, .rangeOut
	);
	ckg_sil_model u_sil (
		.clk, .rst, .enableReq, .baseClockOut, .oscEnableIn, .highLen, .lowLen
	);

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// source periods 8, 6 and 10 cycles, kept off the sampling edge
	initial begin
		#3;
		fork
			forever #80 crystalClock = ~crystalClock;
			forever #60 loopClock = ~loopClock;
			forever #100 vcoClock = ~vcoClock;
			forever #70 oscInput = ~oscInput;
		join
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nChecks++;
		if (got !== exp) begin
			failCount++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWriteData <= w;
		@(posedge clk);
		regWrite <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'h0;
		#1;
		chk(16'(regReadData), 16'(e));
	endtask
	task automatic usbHalf(input int e);
		logic v;
		int n;
		@(posedge clk);
		v = usbRefClock;
		while (usbRefClock === v) @(posedge clk);
		v = usbRefClock;
		n = 0;
		while (usbRefClock === v) begin
			@(posedge clk);
			n++;
		end
		chk(16'(n), 16'(e));
	endtask
	task automatic endSim();
		$display("checks %0d, mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic tReset();
		rd(CTL, 8'h20);
		rd(ckg_pkg::ADDR_MULT_LOW, 8'h02);
		rd(ckg_pkg::ADDR_REF_DIV, 8'h01);
		rd(8'h3e, 8'h00);
	endtask
	task automatic tProgram();
		wr(CTL, 8'h00);
		repeat (2) @(posedge clk);
		chk(16'(loopEnable), 16'h0);
		for (int p = 0; p < 4; p++) begin
			wr(CTL, 8'(p << 2));
			chk(16'(prescaleOut), 16'(p));
		end
		wr(ckg_pkg::ADDR_MULT_HIGH, 8'h00);
		wr(ckg_pkg::ADDR_MULT_LOW, 8'h00);
		wr(ckg_pkg::ADDR_REF_DIV, 8'h00);
		chk(16'(multiplierOut), 16'h1);
		chk(16'(refDividerOut), 16'h1);
		wr(ckg_pkg::ADDR_MULT_LOW, 8'h04);
		wr(ckg_pkg::ADDR_REF_DIV, 8'h01);
		wr(CTL, 8'h04);
		wr(CTL, 8'h24);
		// locked while the loop is powered
		wr(ckg_pkg::ADDR_MULT_LOW, 8'h09);
		chk(16'(multiplierOut), 16'h4);
		chk(16'(prescaleOut), 16'h1);
	endtask
	task automatic tInterlock();
		wr(CTL, 8'h04);
		wr(CTL, 8'h34);
		rd(CTL, 8'h24);
		wr(CTL, 8'h34);
		rd(CTL, 8'h34);
		wr(CTL, 8'h14);
		rd(CTL, 8'h34);
		wr(CTL, 8'h24);
		wr(CTL, 8'h04);
		wr(ckg_pkg::ADDR_RANGE, 8'h00);
		chk(16'(rangeOut), 16'h0);
		wr(CTL, 8'h24);
		wr(CTL, 8'h34);
		rd(CTL, 8'h24);
		chk(16'(loopEnable), 16'h0);
		wr(CTL, 8'h04);
		wr(ckg_pkg::ADDR_RANGE, 8'h01);
		chk(16'(rangeOut), 16'h1);
		wr(CTL, 8'h24);
	endtask
	task automatic tBase();
		logic b, chg;
		repeat (100) @(posedge clk);
		chk(16'(highLen), 16'h8);
		chk(16'(highLen + lowLen), 16'h10);
		usbHalf(4);
		wr(CTL, 8'h34);
		repeat (2) @(posedge clk);
		b = baseClockOut;
		chg = 1'h0;
		repeat (20) begin
			@(posedge clk);
			if (baseClockOut !== b) chg = 1'h1;
		end
		chk(16'(chg), 16'h0);
		repeat (100) @(posedge clk);
		chk(16'(highLen), 16'h6);
		chk(16'(lowLen), 16'h6);
		usbHalf(5);
		wr(CTL, 8'h24);
		repeat (100) @(posedge clk);
		chk(16'(highLen + lowLen), 16'h10);
	endtask
	task automatic tLock();
		acqDetect <= 1'h1;
		wr(BW, 8'h80);
		chk(16'(autoBandwidth), 16'h1);
		wr(CTL, 8'ha4);
		rd(CTL, 8'ha4);
		lockDetect <= 1'h1;
		repeat (6) @(posedge clk);
		chk(16'(lockChangeIrq), 16'h1);
		rd(CTL, 8'he4);
		chk(16'(lockChangeIrq), 16'h0);
		rd(BW, 8'he0);
		wr(CTL, 8'h24);
		lockDetect <= 1'h0;
		repeat (6) @(posedge clk);
		chk(16'(lockChangeIrq), 16'h0);
		rd(CTL, 8'h64);
		wr(BW, 8'h00);
		chk(16'(autoBandwidth), 16'h0);
		wr(CTL, 8'ha4);
		rd(CTL, 8'h24);
	endtask
	task automatic tOsc();
		enableReq <= 1'h0;
		repeat (4) @(posedge clk);
		chk(16'({crystalOscEnable, loopEnable}), 16'h0);
		enableReq <= 1'h1;
		repeat (4) @(posedge clk);
		chk(16'({crystalOscEnable, loopEnable}), 16'h3);
	endtask

	initial begin
		rst = 1'h1;
		regWrite = 1'h0;
		regRead = 1'h0;
		regAddr = 8'h00;
		regWriteData = 8'h00;
		crystalClock = 1'h0;
		loopClock = 1'h0;
		vcoClock = 1'h0;
		oscInput = 1'h0;
		lockDetect = 1'h0;
		acqDetect = 1'h0;
		enableReq = 1'h1;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		tReset();
		tProgram();
		tInterlock();
		tBase();
		tLock();
		tOsc();
		endSim();
	end
	initial begin
		repeat (5000) @(posedge clk);
		failCount++;
		endSim();
	end
endmodule

bind ckg_base_clock_ctrl ckg_ctrl_asserts u_asserts (
	.clk, .rst, .oscInput, .oscEnableIn, .crystalOscEnable, .loopEnable, .baseClockOut,
	.usbRefClock, .bufferedOscOut, .multiplierOut, .refDividerOut, .rangeOut
);
